// [dv/sss_link_asserts.sv]
// link checker: pulse shape, reversal gap and home flag timing seen on the wires
`timescale 1ns/1ps
`default_nettype none
module sss_link_asserts #(
    parameter int HALF_CYC = 4,                  // pulse on and off time
    parameter int GAP_CYC  = 6                   // reversal gap
) (
    input wire logic clk_sys,                    // system clock
    input wire logic rst_n,                      // synchronous reset, low active
    input wire logic cw_or_pulse,                // cw or step pulse line
    input wire logic ccw_or_dir,                 // ccw or direction line
    input wire logic windings_off,               // windings released
    input wire logic step_base_force,            // base-step override
    input wire logic current_cutback_disable,    // cut-back disable
    input wire logic excitation_home_flag        // home flag from device
);
    // ****************************************************************
    // age counters, all but hi_age_reg saturating so long idles never wrap into a pass
    // ****************************************************************
    logic [7:0] hi_age_reg, lo_age_reg, dir_age_reg, fall_age_reg, off_age_reg;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hi_age_reg   <= 8'h00;
            lo_age_reg   <= 8'hff;
            dir_age_reg  <= 8'hff;
            fall_age_reg <= 8'hff;
            off_age_reg  <= 8'hff;
        end else begin
            hi_age_reg   <= cw_or_pulse ? hi_age_reg + 8'h01 : 8'h00;
            lo_age_reg   <= cw_or_pulse ? 8'h00 : lo_age_reg + {7'h00, lo_age_reg != 8'hff};
            dir_age_reg  <= $changed(ccw_or_dir) ? 8'h00 : dir_age_reg + {7'h00, dir_age_reg != 8'hff};
            fall_age_reg <= ($fell(cw_or_pulse) || $fell(ccw_or_dir)) ? 8'h00
                          : fall_age_reg + {7'h00, fall_age_reg != 8'hff};
            off_age_reg  <= windings_off ? 8'h00 : off_age_reg + {7'h00, off_age_reg != 8'hff};
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_RELEASE_HOME: assert property ($rose(rst_n) |-> excitation_home_flag && !cw_or_pulse)
        else $error("home flag or pulse line wrong after reset");
    AST_PULSE_HIGH: assert property ($fell(cw_or_pulse) |-> hi_age_reg == 8'(HALF_CYC + 1))
        else $error("pulse on time wrong");
    AST_PULSE_LOW: assert property ($rose(cw_or_pulse) |-> lo_age_reg >= 8'(HALF_CYC))
        else $error("pulse off time too short");
    AST_REVERSE_GAP: assert property ($rose(cw_or_pulse) |-> dir_age_reg >= 8'(GAP_CYC - 1))
        else $error("pulse too soon after reversal");
    AST_DIR_STEADY: assert property (cw_or_pulse |-> $stable(ccw_or_dir))
        else $error("second line moved during a pulse");
    AST_HOME_CAUSE: assert property ($changed(excitation_home_flag) |-> fall_age_reg inside {[1:6]})
        else $error("home flag moved without a pulse");
    AST_FORCE_AT_HOME: assert property ($changed(step_base_force) |-> excitation_home_flag && !cw_or_pulse)
        else $error("override changed away from home");
    AST_WINDINGS_HOLD: assert property (windings_off && $past(windings_off, 2) |-> !$rose(cw_or_pulse))
        else $error("pulse sent with windings off");
    AST_WINDINGS_SETTLE: assert property ($rose(cw_or_pulse) |-> off_age_reg >= 8'(GAP_CYC - 1))
        else $error("pulse too soon after windings restored");
endmodule : sss_link_asserts
`default_nettype wire

// [dv/tb.sv]
// testbench: controller end driving device end across the link
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sss_pkg::*;
    localparam int HALF = 4;
    localparam int GAP  = 6;
    localparam int CUT  = 50;
    logic clk_sys, rst_n, pulse_mode_switch, division_select_a, division_select_b, division_select_c;
    logic [3:0] run_current_dial, current_level_code;
    logic [6:0] cutback_trim_pct, current_pct, exp_pct;
    logic [5:0] excitation_state, e;
    logic [4:0] active_division;
    logic step_event, req_valid, req_cw, req_ready, windings_off_req, base_step_req;
    logic cutback_disable_req, at_home;
    int err_total, total_checks, seed, pos, div, r;
    logic [5:0] exp_q[$];
    sss_link_if sss_link_if_inst ();
    sss_device #(.CUTBACK_CYC(CUT)) sss_device_inst (.clk_sys, .rst_n, .link(sss_link_if_inst.device),
        .pulse_mode_switch, .division_select_a, .division_select_b, .division_select_c, .run_current_dial,
        .cutback_trim_pct, .excitation_state, .active_division, .current_level_code, .current_pct, .step_event);
    sss_ctrl #(.HALF_CYC(HALF), .GAP_CYC(GAP)) sss_ctrl_inst (.clk_sys, .rst_n, .link(sss_link_if_inst.ctrl),
        .two_pulse_mode(pulse_mode_switch), .req_valid, .req_cw, .req_ready, .windings_off_req, .base_step_req,
        .cutback_disable_req, .at_home);
    sss_link_asserts #(.HALF_CYC(HALF), .GAP_CYC(GAP)) sss_link_asserts_inst (.clk_sys, .rst_n,
        .cw_or_pulse(sss_link_if_inst.cw_or_pulse), .ccw_or_dir(sss_link_if_inst.ccw_or_dir),
        .windings_off(sss_link_if_inst.windings_off), .step_base_force(sss_link_if_inst.step_base_force),
        .current_cutback_disable(sss_link_if_inst.current_cutback_disable),
        .excitation_home_flag(sss_link_if_inst.excitation_home_flag));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // hold valid until the wanted line rises; a reversal may take one handshake without a pulse
    task automatic do_step(input logic cw);
        int n;
        logic hit;
        hit = 1'b0;
        n = 0;
        req_valid <= 1'b1;
        req_cw <= cw;
        while (hit !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
            if (req_ready === 1'b1) begin
                @(posedge clk_sys);
                hit = (pulse_mode_switch && !cw) ? sss_link_if_inst.ccw_or_dir : sss_link_if_inst.cw_or_pulse;
            end
        end
        chk_val("pulse issued", 8'h01, {7'h00, hit});
        pos = cw ? (pos + 1) % (4 * div) : (pos + 4 * div - 1) % (4 * div);
        exp_q.push_back(pos[5:0]);
    endtask : do_step
    task automatic stop_steps;
        @(posedge clk_sys);
        req_valid <= 1'b0;
    endtask : stop_steps
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        err_total++;
        complete_run();
    end
    // each accepted step consumes the oldest expectation
    always @(posedge clk_sys) begin
        if (rst_n === 1'b1 && step_event === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 6'h3f;
            chk_val("state", {2'b00, e}, {2'b00, excitation_state});
            chk_val("home flag", {7'h00, e == 6'h00}, {7'h00, sss_link_if_inst.excitation_home_flag});
        end
    end
    // ****************************************************************
    // main sequence: two-pulse codes first, so idle lines stay off on the mode change
    // ****************************************************************
    initial begin
        seed = 32'h54a825db;
        {rst_n, req_valid, req_cw, windings_off_req, base_step_req, cutback_disable_req} = 6'h00;
        {division_select_a, division_select_b, division_select_c} = 3'h0;
        pulse_mode_switch = 1'b1;
        run_current_dial = 4'hf;
        cutback_trim_pct = 7'h28;
        pos = 0;
        div = 1;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (12) @(posedge clk_sys);
        chk_val("reset state", 8'h00, {2'b00, excitation_state});
        chk_val("reset level", 8'h0f, {4'h0, current_level_code});
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            {division_select_a, division_select_b, division_select_c} <= i[2:0];
            pulse_mode_switch <= !i[3];
            base_step_req <= (i == 5 || i == 12);
            cutback_disable_req <= i[1] & i[0];
            run_current_dial <= r[3:0];
            cutback_trim_pct <= r[10:4];
            repeat (10) @(posedge clk_sys);
            div = (i == 5 || i == 12 || i[2:0] > 4) ? 1 : 1 << i[2:0];
            chk_val("division", div[7:0], {3'b000, active_division});
            chk_val("level code", {4'h0, run_current_dial}, {4'h0, current_level_code});
            for (int k = 0; k < 4 * div + 1; k++) do_step(1'b1);
            repeat (2) do_step(1'b0);
            do_step(1'b1);
            stop_steps();
            repeat (40) @(posedge clk_sys);
            chk_val("run current", {1'b0, PCT_FULL}, {1'b0, current_pct});
            chk_val("at home", 8'h01, {7'h00, at_home});
            repeat (40) @(posedge clk_sys);
            exp_pct = cutback_trim_pct > CUTBACK_PCT_MAX ? CUTBACK_PCT_MAX : cutback_trim_pct;
            exp_pct = cutback_disable_req ? PCT_FULL : exp_pct;
            chk_val("idle current", {1'b0, exp_pct}, {1'b0, current_pct});
        end
        // windings released: no pulse may be taken, then stepping resumes after settling
        // the release must reach the controller before the request rises, or the request slips through
        windings_off_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        req_valid <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk_val("off current", 8'h00, {1'b0, current_pct});
        chk_val("refused", 8'h00, {7'h00, req_ready});
        windings_off_req <= 1'b0;
        req_valid <= 1'b0;
        repeat (20) @(posedge clk_sys);
        do_step(1'b1);
        stop_steps();
        repeat (20) @(posedge clk_sys);
        chk_val("restored current", {1'b0, PCT_FULL}, {1'b0, current_pct});
        chk_val("pending steps", 8'h00, 8'(exp_q.size()));
        complete_run();
    end
endmodule : tb
`default_nettype wire

// [inc/sss_link_if.sv]
// link between the pulse controller and the step sequencer device
`timescale 1ns/1ps
`default_nettype none
interface sss_link_if;
    logic       cw_or_pulse;                // cw pulse, or step_pulse in one-pulse mode
    logic       ccw_or_dir;                 // ccw pulse, or direction level in one-pulse mode
    logic       windings_off;
    logic       step_base_force;            // base-step override
    logic       current_cutback_disable;
    logic       excitation_home_flag;       // device to controller

    modport device (
        input  cw_or_pulse, ccw_or_dir, windings_off, step_base_force, current_cutback_disable,
        output excitation_home_flag
    );
    modport ctrl (
        output cw_or_pulse, ccw_or_dir, windings_off, step_base_force, current_cutback_disable,
        input  excitation_home_flag
    );
endinterface : sss_link_if
`default_nettype wire

// [inc/sss_pkg.sv]
// shared constants and types for the step sequencer, device end and controller end
package sss_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS     = 5000;                 // 200 mhz system clock
    localparam int CUTBACK_DELAY_MS  = 100;                  // standstill cut-back after 0.1 s
    localparam int CUTBACK_CYCLES    = CUTBACK_DELAY_MS * 200_000;
    localparam int REVERSE_GAP_NS    = 10_000;               // 10 us before a reversed pulse
    localparam int REVERSE_GAP_CYC   = (REVERSE_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MAX_RATE_KHZ      = 100;                  // highest pulse rate, 50 % duty
    localparam int MIN_PERIOD_CYC    = (1_000_000_000 / MAX_RATE_KHZ + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MIN_HALF_CYC      = (MIN_PERIOD_CYC + 1) / 2;

    // ****************************************************************
    // counter and current codes
    // ****************************************************************
    localparam int          FULL_STEPS_PER_CYCLE = 4;        // home repeats every four full steps
    localparam int          MAX_DIVISION         = 16;
    localparam int          POS_W                = 6;        // holds 0 .. 4*16-1
    localparam logic [5:0]  HOME_STATE           = 6'h00;
    localparam logic [3:0]  RUN_CURRENT_DEFAULT  = 4'hf;     // rated current
    localparam logic [6:0]  CUTBACK_PCT_MAX      = 7'h28;    // 40 %
    localparam logic [6:0]  CUTBACK_PCT_DEFAULT  = 7'h28;
    localparam logic [6:0]  PCT_FULL             = 7'h64;    // 100 %, full current
    localparam logic [6:0]  PCT_NONE             = 7'h00;

    // division select code {a,b,c}
    localparam logic [2:0]  DIV_CODE_1  = 3'h0;
    localparam logic [2:0]  DIV_CODE_2  = 3'h1;
    localparam logic [2:0]  DIV_CODE_4  = 3'h2;
    localparam logic [2:0]  DIV_CODE_8  = 3'h3;
    localparam logic [2:0]  DIV_CODE_16 = 3'h4;

    typedef enum logic [2:0] {
        SSS_PH_IDLE = 3'b001,    // nothing sent yet or after a gap
        SSS_PH_HIGH = 3'b010,    // pulse line on
        SSS_PH_LOW  = 3'b100     // pulse line off, spacing
    } sss_phase_e;
endpackage : sss_pkg

// [logic/sss_ctrl.sv]
// controller end: turns step requests into pulses with spacing and reversal gap
`timescale 1ns/1ps
`default_nettype none
module sss_ctrl
    import sss_pkg::*;
#(
    parameter int HALF_CYC = sss_pkg::MIN_HALF_CYC,      // on and off time of one pulse
    parameter int GAP_CYC  = sss_pkg::REVERSE_GAP_CYC    // wait after a reversal
) (
    input  wire logic clk_sys,                           // 200 mhz system clock
    input  wire logic rst_n,                             // synchronous reset, low active
    sss_link_if.ctrl  link,                              // pins to the device
    input  wire logic two_pulse_mode,                    // must match the device mode switch
    input  wire logic req_valid,                         // step request
    input  wire logic req_cw,                            // direction of the request
    output logic      req_ready,                         // request taken this cycle
    input  wire logic windings_off_req,                  // release the windings
    input  wire logic base_step_req,                     // wanted override level
    input  wire logic cutback_disable_req,               // wanted cut-back disable level
    output logic      at_home                            // synchronised home flag
);
    import sss_pkg::*;

    typedef struct packed {
        sss_phase_e  ph;
        logic [15:0] cnt;
        logic        dir;
        logic        cw_o;
        logic        ccw_o;
        logic        wnd_off;
        logic        base;
        logic        cbd;
        logic [1:0]  home_sync;      // bit 0 read only by bit 1
    } sss_ctl_s;

    sss_ctl_s st_reg;
    sss_ctl_s st_next;
    logic     busy_gap;

    // ****************************************************************
    // pulse generator
    // ****************************************************************
    // a request is taken only when idle or spacing is over and no reversal gap runs
    assign busy_gap  = (st_reg.cnt != 16'h0);
    assign req_ready = req_valid && !busy_gap && st_reg.ph != SSS_PH_HIGH && !st_reg.wnd_off;

    always_comb begin
        st_next           = st_reg;
        st_next.home_sync = {st_reg.home_sync[0], link.excitation_home_flag};
        st_next.wnd_off   = windings_off_req;
        st_next.cbd       = 1'b0;
        st_next.cbd       = cutback_disable_req;         // caller normally leaves it low
        if (busy_gap) begin
            st_next.cnt = st_reg.cnt - 16'h1;
        end
        // restoring released windings waits out a settling time; a pulse already on is left alone
        if (st_reg.wnd_off && !windings_off_req && st_reg.ph != SSS_PH_HIGH) begin
            st_next.cnt = 16'(GAP_CYC);
        end
        case (st_reg.ph)
            SSS_PH_IDLE, SSS_PH_LOW: begin
                if (st_reg.ph == SSS_PH_LOW && !busy_gap) begin
                    st_next.ph = SSS_PH_IDLE;
                end
                // override may change only while stopped and at home
                if (st_reg.home_sync[1] && !busy_gap && !req_ready) begin
                    st_next.base = base_step_req;
                end
                if (req_ready) begin
                    // one-pulse compares with the direction pin itself, so a mode change cannot leave it stale
                    if (two_pulse_mode ? (req_cw != st_reg.dir) : (req_cw != st_reg.ccw_o)) begin
                        st_next.dir = req_cw;            // reversal: swap, then wait
                        st_next.cnt = 16'(GAP_CYC);
                        if (!two_pulse_mode) begin
                            st_next.ccw_o = req_cw;      // direction level
                        end
                    end else if (two_pulse_mode) begin
                        st_next.cw_o  = req_cw;          // only one line at a time
                        st_next.ccw_o = !req_cw;
                        st_next.ph    = SSS_PH_HIGH;
                        st_next.cnt   = 16'(HALF_CYC);
                    end else begin
                        st_next.cw_o = 1'b1;
                        st_next.ph   = SSS_PH_HIGH;
                        st_next.cnt  = 16'(HALF_CYC);
                    end
                end
            end
            SSS_PH_HIGH: begin
                if (!busy_gap) begin
                    st_next.cw_o = 1'b0;                 // falling edge is the step
                    if (two_pulse_mode) begin
                        st_next.ccw_o = 1'b0;
                    end
                    st_next.ph  = SSS_PH_LOW;
                    st_next.cnt = 16'(HALF_CYC);
                end
            end
            default: begin
                st_next.ph = SSS_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg     <= '0;
            st_reg.ph  <= SSS_PH_IDLE;
            st_reg.dir <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.cw_or_pulse             = st_reg.cw_o;
    assign link.ccw_or_dir              = st_reg.ccw_o;
    assign link.windings_off            = st_reg.wnd_off;
    assign link.step_base_force         = st_reg.base;
    assign link.current_cutback_disable = st_reg.cbd;
    assign at_home                      = st_reg.home_sync[1];
endmodule : sss_ctrl
`default_nettype wire

// [logic/sss_device.sv]
// step sequencer device end: pulse decoding, microstep counter, home flag, current level
`timescale 1ns/1ps
`default_nettype none

module sss_device
    import sss_pkg::*;
#(
    parameter int CUTBACK_CYC = sss_pkg::CUTBACK_CYCLES      // shorten for simulation
) (
    input  wire logic       clk_sys,                     // 200 mhz system clock
    input  wire logic       rst_n,                       // synchronous reset, low active
    sss_link_if.device      link,                        // pins from the controller
    input  wire logic       pulse_mode_switch,           // on: two-pulse mode
    input  wire logic       division_select_a,           // division switch a
    input  wire logic       division_select_b,           // division switch b
    input  wire logic       division_select_c,           // division switch c
    input  wire logic [3:0] run_current_dial,            // operating current code
    input  wire logic [6:0] cutback_trim_pct,            // standstill ratio, percent
    output logic      [5:0] excitation_state,            // microstep counter
    output logic      [4:0] active_division,             // divisions now in use
    output logic      [3:0] current_level_code,          // operating current code in use
    output logic      [6:0] current_pct,                 // 100 run, ratio standstill, 0 off
    output logic            step_event                   // one cycle per accepted step
);
    import sss_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [5:0]  sync1;          // first synchroniser stage, read only by sync2
        logic [5:0]  sync2;
        logic [5:0]  last;           // previous synchronised value, edge detect
        logic [5:0]  pos;
        logic [31:0] idle_cnt;
        logic        standstill;
        logic [6:0]  pct;
        logic        mode_s1;        // mode switch, first stage, read only by mode_s2
        logic        mode_s2;
        logic [3:0]  dial_s1;        // dial, first stage, read only by dial
        logic [3:0]  dial;
        logic [6:0]  trim_s1;        // ratio trim, first stage, read only by trim_s2
        logic [6:0]  trim_s2;
        logic        step;
    } sss_dev_s;

    sss_dev_s st_reg;
    sss_dev_s st_next;

    logic [4:0] div_n;
    logic [5:0] wrap;
    logic       cw_fall;
    logic       ccw_fall;
    logic       adv;
    logic       dir_cw;
    logic [6:0] trim;

    // ****************************************************************
    // division decode
    // ****************************************************************
    always_comb begin
        logic [2:0] code;
        code = {st_reg.sync2[4], st_reg.sync2[3], st_reg.sync2[2]};
        if (st_reg.sync2[5]) begin
            div_n = 5'h01;
        end else if (code == DIV_CODE_2) begin
            div_n = 5'h02;
        end else if (code == DIV_CODE_4) begin
            div_n = 5'h04;
        end else if (code == DIV_CODE_8) begin
            div_n = 5'h08;
        end else if (code == DIV_CODE_16) begin
            div_n = 5'h10;
        end else begin
            div_n = 5'h01;                               // code 0 and undefined codes
        end
    end

    // counter modulus: four full steps times the division, worked at seven bits so 4 x 16 cannot wrap early
    assign wrap = 6'(7'(div_n) * 7'(FULL_STEPS_PER_CYCLE) - 7'h01);

    // edges on synchronised pulse lines; in two-pulse mode both lines act on on-to-off
    assign cw_fall  = st_reg.last[0] & ~st_reg.sync2[0];
    assign ccw_fall = st_reg.last[1] & ~st_reg.sync2[1];
    // two-pulse: either line steps its own way; one-pulse: line 0 steps, line 1 is direction
    assign adv    = st_reg.mode_s2 ? (cw_fall ^ ccw_fall) : cw_fall;
    assign dir_cw = st_reg.mode_s2 ? cw_fall : st_reg.sync2[1];
    // the ratio trim is clamped so a bad setting can never exceed the cut-back limit
    assign trim   = (st_reg.trim_s2 > CUTBACK_PCT_MAX) ? CUTBACK_PCT_MAX : st_reg.trim_s2;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = {link.step_base_force, division_select_a, division_select_b,
                         division_select_c, link.ccw_or_dir, link.cw_or_pulse};
        st_next.sync2 = st_reg.sync1;
        st_next.last  = st_reg.sync2;
        st_next.step  = adv;
        st_next.mode_s1 = pulse_mode_switch;
        st_next.mode_s2 = st_reg.mode_s1;
        st_next.dial_s1 = run_current_dial;
        st_next.dial    = st_reg.dial_s1;
        st_next.trim_s1 = cutback_trim_pct;
        st_next.trim_s2 = st_reg.trim_s1;
        // simultaneous falls in two-pulse mode cancel; the controller must not do that
        if (adv) begin
            if (dir_cw) begin
                st_next.pos = (st_reg.pos >= wrap) ? HOME_STATE : st_reg.pos + 6'h01;
            end else begin
                st_next.pos = (st_reg.pos == HOME_STATE || st_reg.pos > wrap) ? wrap
                            : st_reg.pos - 6'h01;
            end
        end
        // idle timer restarts on every accepted pulse
        if (adv) begin
            st_next.idle_cnt   = 32'h0;
            st_next.standstill = 1'b0;
        end else if (st_reg.idle_cnt >= 32'(CUTBACK_CYC - 1)) begin
            st_next.standstill = 1'b1;
        end else begin
            st_next.idle_cnt = st_reg.idle_cnt + 32'h1;
        end
        // current level: off wins, then cut-back unless disabled
        if (link.windings_off) begin
            st_next.pct = PCT_NONE;
        end else if (st_reg.standstill && !link.current_cutback_disable) begin
            st_next.pct = trim;
        end else begin
            st_next.pct = PCT_FULL;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg      <= '0;                           // counter starts at home
            st_reg.pct  <= PCT_FULL;
            st_reg.dial <= RUN_CURRENT_DEFAULT;
            st_reg.dial_s1 <= RUN_CURRENT_DEFAULT;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.excitation_home_flag = (st_reg.pos == HOME_STATE);
    assign excitation_state   = st_reg.pos;
    assign active_division    = div_n;
    assign current_level_code = st_reg.dial;
    assign current_pct        = st_reg.pct;
    assign step_event         = st_reg.step;
endmodule : sss_device
`default_nettype wire
